/* design/civ_pkg.sv */
// Purpose: constants and carriers for the can interrupt-vector / time-base block
// Assumes: 16-bit register port, word addresses 0 to 7
// Notes:   all codes are 7 bits, all register words 16 bits
package civ_pkg;
    // register word addresses
    localparam logic [2:0] ADDR_PRESCALE = 3'h0;
    localparam logic [2:0] ADDR_FIFO_VEC = 3'h1;
    localparam logic [2:0] ADDR_COMB_VEC = 3'h2;
    localparam logic [2:0] ADDR_IRQ_EN   = 3'h3;
    localparam logic [2:0] ADDR_FLAGS    = 3'h4;
    localparam logic [2:0] ADDR_TB_CTRL  = 3'h5;
    localparam logic [2:0] ADDR_TB_LOW   = 3'h6;
    localparam logic [2:0] ADDR_TB_HIGH  = 3'h7;

    // vector codes
    localparam logic [6:0] CODE_NONE = 7'h40;
    localparam logic [6:0] CODE_TXAT = 7'h4A;
    localparam logic [6:0] CODE_TEF  = 7'h49;
    localparam logic [6:0] CODE_IVM  = 7'h48;
    localparam logic [6:0] CODE_MODE = 7'h47;
    localparam logic [6:0] CODE_TMR  = 7'h46;
    localparam logic [6:0] CODE_ASMB = 7'h45;
    localparam logic [6:0] CODE_ADDR = 7'h44;
    localparam logic [6:0] CODE_RXOV = 7'h43;
    localparam logic [6:0] CODE_WAKE = 7'h42;
    localparam logic [6:0] CODE_BERR = 7'h41;

    // bit positions shared by enable and flag words; B_TBEN is the time-base control bit
    localparam int unsigned B_IVM  = 15;
    localparam int unsigned B_WAK  = 14;
    localparam int unsigned B_BERR = 13;
    localparam int unsigned B_SERR = 12;
    localparam int unsigned B_RXOV = 11;
    localparam int unsigned B_TXAT = 10;
    localparam int unsigned B_TEF  = 4;
    localparam int unsigned B_MODE = 3;
    localparam int unsigned B_TMR  = 2;
    localparam int unsigned B_RX   = 1;
    localparam int unsigned B_TX   = 0;
    localparam int unsigned B_TBEN = 0;

    // field placement and masks
    localparam int unsigned RX_LSB   = 8;
    localparam int unsigned FILT_LSB = 8;
    localparam logic [15:0] EN_MASK  = 16'hFC1F;

    // reset values; TB_MAX is the counter value at which it wraps
    localparam logic [15:0] RST_IRQ_EN   = 16'h0000;
    localparam logic [9:0]  RST_PRESCALE = 10'h000;
    localparam logic [31:0] TB_MAX       = 32'hFFFF_FFFF;

    // hardware event pulses from the protocol engine
    typedef struct packed {
        logic invalid_msg;
        logic wakeup;
        logic bus_error;
        logic asm_error;
        logic addr_error;
        logic mode_change;
    } civ_evt_t;

    // level sources from fifo and status logic
    typedef struct packed {
        logic [7:0] rx_fifo_pending;
        logic [7:0] tx_fifo_pending;
        logic [7:0] tx_attempt_status;
        logic [7:0] tx_event_fifo_status;
        logic [7:0] rx_overflow_status;
        logic [4:0] matched_filter_number;
    } civ_src_t;

    // complete register state
    typedef struct packed {
        logic [9:0]  prescale;
        logic [15:0] irq_en;
        logic        invalid_msg_flag;
        logic        wakeup_flag;
        logic        bus_error_flag;
        logic        asm_flag;
        logic        addr_flag;
        logic        mode_change_flag;
        logic        timer_overflow_flag;
        logic        tb_en;
        logic [9:0]  presc_cnt;
        logic [31:0] counter;
        logic [15:0] rd_data;
    } civ_state_t;
endpackage

/* design/civ_top.sv */
// Purpose: time-base prescaler/counter, fifo and module interrupt vector codes, enables
// Assumes: one clock, synchronous active-high reset, inputs synchronous to ref_clk_i
// Notes:   vector fields are combinational from the current flags and source levels
//
// Contract
// - counter steps every prescale plus one clocks
// - prescale zero steps counter every clock
// - rx vector reads none code when idle
// - rx vector shows pending fifo number
// - rx vector never reports fifo zero
// - tx vector reads none code when idle
// - tx vector shows fifo number, zero included
// - read-only field gives matched filter number
// - combined vector reports pending fifo number
// - combined reports transmit attempt status code
// - combined reports transmit event fifo code
// - combined reports invalid message code
// - combined reports mode change code
// - combined reports timer overflow code
// - combined reports assembly buffer over/underflow
// - combined reports illegal fifo address code
// - combined reports receive overflow status code
// - combined reports wake-up and bus error codes
// - combined reads none code when idle
// - high enable bits gate six interrupts
// - low enable bits gate five interrupts
// - unimplemented bits read zero, writes ignored
// - enable runs counter, clearing stops and zeroes
// - counter write restarts prescaler, keeps prescale
// - hardware sets flags, software clears them
//
// Local design decisions: the strobed register port and the placing of the registers.
module civ_top
    import civ_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [2:0]  addr_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire civ_evt_t    evt_i,
    input  wire civ_src_t    src_i,
    output logic      [15:0] rd_data_o,
    output logic      [31:0] timebase_counter_o
);
    civ_state_t q;            // registered state
    civ_state_t d;            // next state
    logic [6:0] rx_code;      // rx vector field
    logic [6:0] tx_code;      // tx vector field
    logic [6:0] comb_code;    // combined vector field
    logic       tick;         // prescaler terminal count
    logic [15:0] flag_word;   // flags as software sees them
    logic [7:0] fifo_any;     // per fifo tx or rx, enabled

    // lowest pending fifo wins; none code when nothing pending
    function automatic logic [6:0] fifo_code(input logic [7:0] p);
        logic [6:0] c;
        c = CODE_NONE;
        for (int i = 7; i >= 0; i--)
        begin
            if (p[i])
            begin
                c = 7'(i);
            end
        end
        return c;
    endfunction

    // vector encoding and next-state logic
    always_comb
    begin
        d = q;
        // bit zero forced low: fifo zero cannot receive
        rx_code = fifo_code({src_i.rx_fifo_pending[7:1], 1'b0});
        tx_code = fifo_code(src_i.tx_fifo_pending);
        fifo_any = ({8{q.irq_en[B_TX]}} & src_i.tx_fifo_pending)
                 | ({8{q.irq_en[B_RX]}} & {src_i.rx_fifo_pending[7:1], 1'b0});
        // fixed priority, highest code first; fifos last
        if (q.irq_en[B_TXAT] && (|src_i.tx_attempt_status))
        begin
            comb_code = CODE_TXAT;
        end
        else if (q.irq_en[B_TEF] && (|src_i.tx_event_fifo_status))
        begin
            comb_code = CODE_TEF;
        end
        else if (q.irq_en[B_IVM] && q.invalid_msg_flag)
        begin
            comb_code = CODE_IVM;
        end
        else if (q.irq_en[B_MODE] && q.mode_change_flag)
        begin
            comb_code = CODE_MODE;
        end
        else if (q.irq_en[B_TMR] && q.timer_overflow_flag)
        begin
            comb_code = CODE_TMR;
        end
        else if (q.irq_en[B_SERR] && q.asm_flag)
        begin
            comb_code = CODE_ASMB;
        end
        else if (q.irq_en[B_SERR] && q.addr_flag)
        begin
            comb_code = CODE_ADDR;
        end
        else if (q.irq_en[B_RXOV] && (|src_i.rx_overflow_status))
        begin
            comb_code = CODE_RXOV;
        end
        else if (q.irq_en[B_WAK] && q.wakeup_flag)
        begin
            comb_code = CODE_WAKE;
        end
        else if (q.irq_en[B_BERR] && q.bus_error_flag)
        begin
            comb_code = CODE_BERR;
        end
        else
        begin
            comb_code = fifo_code(fifo_any);
        end

        // software view of the flags
        flag_word = 16'h0000;
        flag_word[B_IVM]  = q.invalid_msg_flag;
        flag_word[B_WAK]  = q.wakeup_flag;
        flag_word[B_BERR] = q.bus_error_flag;
        flag_word[B_SERR] = q.asm_flag | q.addr_flag;
        flag_word[B_RXOV] = |src_i.rx_overflow_status;
        flag_word[B_TXAT] = |src_i.tx_attempt_status;
        flag_word[B_TEF]  = |src_i.tx_event_fifo_status;
        flag_word[B_MODE] = q.mode_change_flag;
        flag_word[B_TMR]  = q.timer_overflow_flag;
        flag_word[B_RX]   = |src_i.rx_fifo_pending[7:1];
        flag_word[B_TX]   = |src_i.tx_fifo_pending;

        // prescaler: terminal count at prescale gives prescale+1 clocks
        tick = q.tb_en && (q.presc_cnt >= q.prescale);
        if (q.tb_en)
        begin
            if (tick)
            begin
                d.presc_cnt = 10'h000;
                d.counter = q.counter + 32'h0000_0001;
            end
            else
            begin
                d.presc_cnt = q.presc_cnt + 10'h001;
            end
        end

        // register writes; unimplemented bits are masked off
        if (wr_i)
        begin
            if (addr_i == ADDR_PRESCALE)
            begin
                d.prescale = wr_data_i[9:0];
            end
            else if (addr_i == ADDR_IRQ_EN)
            begin
                d.irq_en = wr_data_i & EN_MASK;
            end
            else if (addr_i == ADDR_FLAGS)
            begin
                // writing zero clears; one leaves the flag alone
                d.invalid_msg_flag    = q.invalid_msg_flag & wr_data_i[B_IVM];
                d.wakeup_flag         = q.wakeup_flag & wr_data_i[B_WAK];
                d.bus_error_flag      = q.bus_error_flag & wr_data_i[B_BERR];
                d.asm_flag            = q.asm_flag & wr_data_i[B_SERR];
                d.addr_flag           = q.addr_flag & wr_data_i[B_SERR];
                d.mode_change_flag    = q.mode_change_flag & wr_data_i[B_MODE];
                d.timer_overflow_flag = q.timer_overflow_flag & wr_data_i[B_TMR];
            end
            else if (addr_i == ADDR_TB_CTRL)
            begin
                d.tb_en = wr_data_i[B_TBEN];
            end
            else if (addr_i == ADDR_TB_LOW)
            begin
                d.counter[15:0] = wr_data_i;
                d.presc_cnt = 10'h000;
            end
            else if (addr_i == ADDR_TB_HIGH)
            begin
                d.counter[31:16] = wr_data_i;
                d.presc_cnt = 10'h000;
            end
        end

        // stopped counter is held at zero to save power
        if (!d.tb_en)
        begin
            d.counter = 32'h0000_0000;
            d.presc_cnt = 10'h000;
        end

        // hardware sets after the clear so a same-cycle event survives
        if (evt_i.invalid_msg)
        begin
            d.invalid_msg_flag = 1'b1;
        end
        if (evt_i.wakeup)
        begin
            d.wakeup_flag = 1'b1;
        end
        if (evt_i.bus_error)
        begin
            d.bus_error_flag = 1'b1;
        end
        if (evt_i.asm_error)
        begin
            d.asm_flag = 1'b1;
        end
        if (evt_i.addr_error)
        begin
            d.addr_flag = 1'b1;
        end
        if (evt_i.mode_change)
        begin
            d.mode_change_flag = 1'b1;
        end
        if (tick && (q.counter == TB_MAX))
        begin
            d.timer_overflow_flag = 1'b1;
        end

        // read data stands only in the cycle after the strobe
        d.rd_data = 16'h0000;
        if (rd_i)
        begin
            if (addr_i == ADDR_PRESCALE)
            begin
                d.rd_data = {6'h00, q.prescale};
            end
            else if (addr_i == ADDR_FIFO_VEC)
            begin
                d.rd_data = {1'b0, rx_code, 1'b0, tx_code};
            end
            else if (addr_i == ADDR_COMB_VEC)
            begin
                d.rd_data = {3'h0, src_i.matched_filter_number, 1'b0, comb_code};
            end
            else if (addr_i == ADDR_IRQ_EN)
            begin
                d.rd_data = q.irq_en;
            end
            else if (addr_i == ADDR_FLAGS)
            begin
                d.rd_data = flag_word;
            end
            else if (addr_i == ADDR_TB_CTRL)
            begin
                d.rd_data = {15'h0000, q.tb_en};
            end
            else if (addr_i == ADDR_TB_LOW)
            begin
                d.rd_data = q.counter[15:0];
            end
            else
            begin
                d.rd_data = q.counter[31:16];
            end
        end
    end

    // state register with synchronous reset
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.prescale <= RST_PRESCALE;
            q.irq_en <= RST_IRQ_EN;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from flip-flops
    assign rd_data_o = q.rd_data;
    assign timebase_counter_o = q.counter;

    // counter steps at terminal count
    AST_PRESC_STEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (q.tb_en && (q.presc_cnt == q.prescale) && !wr_i)
        |=> (q.counter == $past(q.counter) + 32'h0000_0001))
        else $error("counter did not step at terminal count");

    // counter holds before terminal count
    AST_PRESC_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (q.tb_en && (q.presc_cnt < q.prescale) && !wr_i)
        |=> $stable(q.counter))
        else $error("counter stepped early");

    // zero prescale steps every clock
    AST_PRESC_ZERO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (q.tb_en && (q.prescale == 10'h000) && !wr_i) [*2]
        |=> (q.counter == $past(q.counter, 2) + 32'h0000_0002))
        else $error("zero prescale did not step every clock");

    // stopped counter stays zero
    AST_TB_STOP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !q.tb_en |-> (q.counter == 32'h0000_0000) && (q.presc_cnt == 10'h000))
        else $error("stopped counter not zero");

    // counter write restarts prescaler, keeps prescale
    AST_TB_WR_RESTART: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (wr_i && ((addr_i == ADDR_TB_LOW) || (addr_i == ADDR_TB_HIGH)))
        |=> (q.presc_cnt == 10'h000) && $stable(q.prescale))
        else $error("counter write did not restart prescaler");

    // idle rx vector read returns none code
    AST_RX_NONE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_i && (addr_i == ADDR_FIFO_VEC) && (src_i.rx_fifo_pending[7:1] == 7'h00))
        |=> (rd_data_o[14:8] == CODE_NONE))
        else $error("rx vector not none when idle");

    // fifo zero transmit reports code zero
    AST_TX_FIFO0: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_i && (addr_i == ADDR_FIFO_VEC) && src_i.tx_fifo_pending[0])
        |=> (rd_data_o[6:0] == 7'h00))
        else $error("tx vector wrong for fifo zero");

    // filter number passes to read data
    AST_FILTER: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_i && (addr_i == ADDR_COMB_VEC))
        |=> (rd_data_o[12:8] == $past(src_i.matched_filter_number)) && (rd_data_o[15:13] == 3'h0))
        else $error("filter number mismatch");

    // timer code only with flag and enable
    AST_TMR_GATE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (comb_code == CODE_TMR) |-> (q.timer_overflow_flag && q.irq_en[B_TMR]))
        else $error("timer code without flag and enable");

    // wake-up flag stays set until software writes
    AST_FLAG_STICKY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (q.wakeup_flag && !(wr_i && (addr_i == ADDR_FLAGS)))
        |=> q.wakeup_flag)
        else $error("flag dropped without software clear");

    // set wins over same-cycle clear
    AST_SET_WINS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (evt_i.bus_error && wr_i && (addr_i == ADDR_FLAGS))
        |=> q.bus_error_flag)
        else $error("event lost against clear");

    // unimplemented enable bits read zero
    AST_EN_RESERVED: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_i && (addr_i == ADDR_IRQ_EN))
        |=> ((rd_data_o & ~EN_MASK) == 16'h0000))
        else $error("reserved enable bits not zero");

    // nothing enabled gives none code
    AST_COMB_NONE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (q.irq_en == 16'h0000) |-> (comb_code == CODE_NONE))
        else $error("combined vector not none with all disabled");

    // rx vector never shows fifo zero; spare bits stay low
    AST_RX_NOT_ZERO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_i && (addr_i == ADDR_FIFO_VEC))
        |=> (rd_data_o[14:8] != 7'h00) && !rd_data_o[15] && !rd_data_o[7])
        else $error("rx vector reported fifo zero or spare bit set");

    // lowest pending rx fifo one reports code one
    AST_RX_FIFO1: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (rd_i && (addr_i == ADDR_FIFO_VEC) && src_i.rx_fifo_pending[1])
        |=> (rd_data_o[14:8] == 7'h01))
        else $error("rx vector wrong for fifo one");

    // combined code stays out of the reserved ranges
    AST_COMB_LEGAL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (comb_code <= CODE_TXAT) && ((comb_code >= CODE_NONE) || (comb_code <= 7'h07)))
        else $error("combined code in reserved range");
endmodule

/* tb/civ_host_model.sv */
// Purpose: host software model that owns the register port of the vector block
// Assumes: strobes change by non-blocking assignment right after a rising edge
// Notes:   every access ends with its strobe low, so two calls never meet at one edge
module civ_host_model
(
    input  wire logic        clk_i,
    input  wire logic [15:0] rd_data_i,
    output logic      [2:0]  addr_o,
    output logic      [15:0] wr_data_o,
    output logic             wr_o,
    output logic             rd_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus from time zero
    initial
    begin
        addr_o = 3'h0;
        wr_data_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // one-cycle write strobe beside address and data
    task automatic write(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wr_data_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe edge
    task automatic read(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rd_data_i;
    endtask
endmodule

/* tb/civ_top_test.sv */
// Purpose: self-checking bench for the interrupt-vector and time-base block
// Assumes: host model owns the register port; bench drives event and source inputs
// Notes:   expected codes come from a bench-side priority model, never from the design
module civ_top_test;
    import civ_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int unsigned LIMIT = 20000; // cycle ceiling, run needs about 7.8k
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  addr;
    logic [15:0] wr_data;
    logic        wr;
    logic        rd;
    civ_evt_t    evt = '0;        // event pulses toward the design
    civ_src_t    src = '0;        // source levels toward the design
    civ_evt_t    e;               // next event pattern
    civ_src_t    s;               // next source pattern
    logic [15:0] rd_data;
    logic [31:0] tb_cnt;
    logic [15:0] en_m = '0;       // model of the enable word
    logic [6:0]  fl_m = '0;       // model flags: ivm wak berr asm addr mode tmr
    logic [15:0] d;
    logic [31:0] a0;
    int          pv[3] = '{0, 3, 1023};
    int          err_count = 0;
    int          num_checks = 0;
    int          cyc = 0;

    // 10 MHz clock
    always #50 ref_clk = ~ref_clk;

    civ_top i_dut (.ref_clk_i(ref_clk), .rst_i(rst), .addr_i(addr), .wr_data_i(wr_data), .wr_i(wr), .rd_i(rd),
                   .evt_i(evt), .src_i(src), .rd_data_o(rd_data), .timebase_counter_o(tb_cnt));
    civ_host_model i_host (.clk_i(ref_clk), .rd_data_i(rd_data), .addr_o(addr), .wr_data_o(wr_data), .wr_o(wr),
                           .rd_o(rd));

    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // single place where the run ends
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // lowest pending fifo number, or the none code
    function automatic logic [6:0] low_fifo(input logic [7:0] p);
        for (int n = 0; n < 8; n++)
            if (p[n])
                return 7'(n);
        return CODE_NONE;
    endfunction

    // fixed-priority model of the combined code, each source gated by its enable
    function automatic logic [6:0] comb_exp();
        logic [7:0] f;
        f = (en_m[B_TX] ? src.tx_fifo_pending : 8'h00) | (en_m[B_RX] ? {src.rx_fifo_pending[7:1], 1'b0} : 8'h00);
        return (en_m[B_TXAT] && |src.tx_attempt_status) ? CODE_TXAT :
               (en_m[B_TEF] && |src.tx_event_fifo_status) ? CODE_TEF :
               (en_m[B_IVM] && fl_m[6]) ? CODE_IVM : (en_m[B_MODE] && fl_m[1]) ? CODE_MODE :
               (en_m[B_TMR] && fl_m[0]) ? CODE_TMR : (en_m[B_SERR] && fl_m[3]) ? CODE_ASMB :
               (en_m[B_SERR] && fl_m[2]) ? CODE_ADDR : (en_m[B_RXOV] && |src.rx_overflow_status) ? CODE_RXOV :
               (en_m[B_WAK] && fl_m[5]) ? CODE_WAKE : (en_m[B_BERR] && fl_m[4]) ? CODE_BERR : low_fifo(f);
    endfunction

    // flag word: sticky bits from the model, the rest from source levels
    function automatic logic [15:0] flags_exp();
        return {fl_m[6:4], fl_m[3] | fl_m[2], |src.rx_overflow_status, |src.tx_attempt_status, 5'h00,
                |src.tx_event_fifo_status, fl_m[1:0], |src.rx_fifo_pending[7:1], |src.tx_fifo_pending};
    endfunction

    // hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            err_count++;
            conclude();
        end
    end

    // main sequence
    initial
    begin
        void'($urandom(46453));
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        // reset value of every word with all sources idle
        for (int a = 0; a < 8; a++)
        begin
            i_host.read(3'(a), d);
            chk("reset word", d, a == 1 ? 16'h4040 : a == 2 ? 16'h0040 : 16'h0000);
        end
        // all-ones writes: only implemented bits stick, read-only words ignore them
        for (int a = 0; a < 4; a++)
        begin
            i_host.write(3'(a), 16'hFFFF);
            i_host.read(3'(a), d);
            chk("write mask", d, a == 0 ? 16'h03FF : a == 1 ? 16'h4040 : a == 2 ? 16'h0040 : EN_MASK);
        end
        en_m = EN_MASK;
        // step count over four whole periods: zero, three and largest field value
        i_host.write(ADDR_TB_CTRL, 16'h0001);
        for (int i = 0; i < 3; i++)
        begin
            i_host.write(ADDR_PRESCALE, 16'(pv[i]));
            @(posedge ref_clk);
            #1;
            a0 = tb_cnt;
            repeat (4 * (pv[i] + 1)) @(posedge ref_clk);
            #1;
            chk("steps", tb_cnt - a0, 32'h0000_0004);
        end
        // a counter write restarts the prescaler, the field keeps its value
        i_host.write(ADDR_PRESCALE, 16'h0003);
        i_host.write(ADDR_TB_LOW, 16'h0100);
        #1;
        chk("restart", tb_cnt[15:0], 16'h0100);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("restart hold", tb_cnt[15:0], 16'h0100);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("restart step", tb_cnt[15:0], 16'h0101);
        i_host.read(ADDR_PRESCALE, d);
        chk("prescale kept", d, 16'h0003);
        i_host.read(ADDR_TB_LOW, d);
        chk("low half", d, 16'h0101);
        // disable stops and zeroes; writes while off are lost
        i_host.write(ADDR_TB_CTRL, 16'h0000);
        #1;
        chk("disabled", tb_cnt, 32'h0000_0000);
        i_host.write(ADDR_TB_LOW, 16'h1234);
        #1;
        chk("write while off", tb_cnt, 32'h0000_0000);
        // wrap from all ones raises the timer flag
        i_host.write(ADDR_PRESCALE, 16'h0000);
        i_host.write(ADDR_TB_CTRL, 16'h0001);
        i_host.write(ADDR_TB_HIGH, 16'hFFFF);
        i_host.read(ADDR_TB_HIGH, d);
        chk("high half", d, 16'hFFFF);
        i_host.write(ADDR_TB_LOW, 16'hFFF0);
        repeat (30) @(posedge ref_clk);
        i_host.write(ADDR_TB_CTRL, 16'h0000);
        fl_m[0] = 1'b1;
        // sparse random sources and events; thin patterns keep low codes reachable
        for (int it = 0; it < 300; it++)
        begin
            d = 16'($urandom);
            i_host.write(ADDR_IRQ_EN, d);
            en_m = d & EN_MASK;
            s = civ_src_t'(45'({$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom} &
                               {$urandom, $urandom}));
            s.matched_filter_number = 5'($urandom % 16);
            e = civ_evt_t'(6'($urandom & $urandom & $urandom));
            @(posedge ref_clk);
            src <= s;
            evt <= e;
            @(posedge ref_clk);
            evt <= '0;
            fl_m[6:1] = fl_m[6:1] | 6'(e);
            i_host.read(ADDR_FIFO_VEC, d);
            chk("fifo vectors", d, {1'b0, low_fifo({src.rx_fifo_pending[7:1], 1'b0}), 1'b0,
                                    low_fifo(src.tx_fifo_pending)});
            i_host.read(ADDR_COMB_VEC, d);
            chk("combined", d, {3'b000, src.matched_filter_number, 1'b0, comb_exp()});
            i_host.read(ADDR_FLAGS, d);
            chk("flags", d, flags_exp());
            // software clears a random subset of the sticky flags
            d = 16'($urandom | $urandom);
            i_host.write(ADDR_FLAGS, d);
            fl_m = fl_m & {d[B_IVM], d[B_WAK], d[B_BERR], d[B_SERR], d[B_SERR], d[B_MODE], d[B_TMR]};
        end
        // a clear and a bus error in the same cycle: the set must win
        e = '0;
        e.bus_error = 1'b1;
        fork
            i_host.write(ADDR_FLAGS, 16'h0000);
            begin
                @(posedge ref_clk);
                evt <= e;
                @(posedge ref_clk);
                evt <= '0;
            end
        join
        fl_m = 7'h10;
        i_host.read(ADDR_FLAGS, d);
        chk("set wins", d, flags_exp());
        conclude();
    end
endmodule
